// ===== amc_pkg.sv
// Purpose: shared constants and types for the automute control register bank
// Assumes: 40 MHz core clock, 24-bit signed audio samples
// Notes: the control port device address is arbitrary and may be changed
package amc_pkg;

  // control port subaddresses of the two registers
  localparam logic [7:0] AMC_SUB_DTH = 8'h14;
  localparam logic [7:0] AMC_SUB_OTB = 8'h15;

  // register reset values
  localparam logic [7:0] AMC_DTH_RST = 8'h00;
  localparam logic [7:0] AMC_OTB_RST = 8'h00;

  // unmapped subaddresses read as this
  localparam logic [7:0] AMC_RD_NONE = 8'h00;

  // device address on the control bus; value is arbitrary
  localparam logic [6:0] AMC_DEV_ADDR = 7'h2A;

  // field layout: two nibbles per register
  localparam int AMC_FLD_W = 4;
  localparam int AMC_LO_LSB = 0;
  localparam int AMC_HI_LSB = 4;
  localparam int AMC_SIGN_BIT = 3;

  // delay code table
  localparam logic [3:0] AMC_DLY_LIN_MAX = 4'h4;
  localparam logic [6:0] AMC_DLY_LIN_OFS = 7'h01;
  localparam logic [6:0] AMC_DLY_STEP_MS = 7'h0A;

  // back-end reset period saturation
  localparam logic [3:0] AMC_BE_MAX_MS = 4'hA;

  // threshold bit range
  localparam logic [4:0] AMC_BIT_MIN = 5'h01;
  localparam logic [3:0] AMC_THR_LIN_MIN = 4'h2;

  // sample and counter widths
  localparam int AMC_SMP_W = 24;
  localparam int AMC_MAG_W = 25;
  localparam int AMC_MS_W = 7;
  localparam int AMC_CYC_W = 24;

  // timing: one millisecond at the core clock period
  localparam int AMC_MS_NS = 1000000;
  localparam int AMC_CLK_NS = 25;
  localparam int AMC_CYC_PER_MS = (AMC_MS_NS + AMC_CLK_NS - 1) / AMC_CLK_NS;

  // control port byte handling
  localparam logic [2:0] AMC_BIT_LAST = 3'h7;

  typedef enum logic [2:0] {
    AMC_ST_IDLE = 3'b000,
    AMC_ST_DEVADR = 3'b001,
    AMC_ST_SUBADR = 3'b010,
    AMC_ST_WRITE = 3'b011,
    AMC_ST_ACK = 3'b100,
    AMC_ST_READ = 3'b101,
    AMC_ST_RACK = 3'b110
  } amc_state_t;

endpackage : amc_pkg

// ===== amc_mute_det.sv
// Purpose: one automute detector, below-threshold timer and mute flag
// Assumes: sample, limit and delay come from logic on core_clk
// Notes: a delay lowered mid-count takes effect at once
`timescale 1ns/1ps
module amc_mute_det (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // channel sample and settings
  input wire logic signed [amc_pkg::AMC_SMP_W-1:0] sample,
  input wire logic [amc_pkg::AMC_MAG_W-1:0] limit,
  input wire logic [amc_pkg::AMC_CYC_W-1:0] delay_cyc,
  // mute state
  output logic mute_reg
);
  import amc_pkg::*;

  logic [AMC_MAG_W-1:0] mag;
  logic [AMC_CYC_W-1:0] cnt_reg;
  logic below;

  // magnitude; the most negative sample still fits unsigned
  always_comb begin
    if (sample[AMC_SMP_W-1]) begin
      mag = {1'b0, AMC_SMP_W'(~sample + AMC_SMP_W'(1))};
    end else begin
      mag = {1'b0, sample};
    end
    below = mag < limit;
  end

  // time spent below threshold, cleared by any louder sample
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (!below) begin
      cnt_reg <= '0;
    end else if (cnt_reg < delay_cyc) begin
      cnt_reg <= cnt_reg + AMC_CYC_W'(1);
    end
  end

  // mute after the full delay, release at once when loud again
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mute_reg <= 1'b0;
    end else if (!below) begin
      mute_reg <= 1'b0;
    end else if (cnt_reg >= delay_cyc) begin
      mute_reg <= 1'b1;
    end
  end

  mute_release_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !below |=> !mute_reg)
    else $error("mute held while signal above threshold");

  mute_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    below && (cnt_reg >= delay_cyc) |=> mute_reg)
    else $error("mute not set after full delay");

  mute_early_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(mute_reg) |-> $past(cnt_reg) >= $past(delay_cyc))
    else $error("mute set before delay expired");

endmodule : amc_mute_det

// ===== amc_top.sv
// Purpose: automute and back-end reset settings reached over the control port
// Assumes: scl and sda arrive from pins; samples come from core_clk logic
// Notes: after a register update, thresholds take one clock to reach the detectors and the delay two
`timescale 1ns/1ps
module amc_top #(
  parameter int unsigned CYC_PER_MS = amc_pkg::AMC_CYC_PER_MS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control port pins, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // audio samples watched by automute
  input wire logic signed [amc_pkg::AMC_SMP_W-1:0] in_sample,
  input wire logic signed [amc_pkg::AMC_SMP_W-1:0] out_sample,
  // mute state and back-end reset period
  output logic in_mute,
  output logic out_mute,
  output logic [amc_pkg::AMC_FLD_W-1:0] be_period_ms
);
  import amc_pkg::*;

  // pin synchronisers and edge history
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic scl_rise, scl_fall, start_det, stop_det;

  // control port state
  amc_state_t state_reg, nxt_reg;
  logic [7:0] shift_reg;
  logic [7:0] sub_reg;
  logic [2:0] bit_cnt_reg;
  logic byte_done_reg;
  logic sda_oe_reg;
  logic wr_stb;
  logic [7:0] rd_byte;

  // configuration registers and decoded settings
  logic [7:0] dth_reg;
  logic [7:0] otb_reg;
  logic [AMC_MS_W-1:0] dly_ms_reg;
  logic [AMC_CYC_W-1:0] dly_cyc_reg;
  logic [4:0] in_bit_reg;
  logic [4:0] out_bit_reg;
  logic [AMC_FLD_W-1:0] be_ms_reg;

  // per-detector wiring, index 0 input side, 1 output side
  logic signed [AMC_SMP_W-1:0] det_smp [2];
  logic [AMC_MAG_W-1:0] det_lim [2];
  logic [1:0] det_mute;

  // delay in ms for a code: linear start then 10 ms steps
  function automatic logic [AMC_MS_W-1:0] dly_ms_of(input logic [3:0] code);
    if (code <= AMC_DLY_LIN_MAX) begin
      dly_ms_of = AMC_MS_W'(code) + AMC_DLY_LIN_OFS;
    end else begin
      dly_ms_of = AMC_MS_W'((code - AMC_DLY_LIN_MAX) * AMC_DLY_STEP_MS);
    end
  endfunction : dly_ms_of

  // input threshold bit; codes 0 and 1 both mean zero signal only
  function automatic logic [4:0] in_bit_of(input logic [3:0] code);
    if (code < AMC_THR_LIN_MIN) begin
      in_bit_of = AMC_BIT_MIN;
    end else begin
      in_bit_of = 5'(code);
    end
  endfunction : in_bit_of

  // output threshold as signed offset from input, clamped at bit 1
  function automatic logic [4:0] out_bit_of(input logic [4:0] inb, input logic [3:0] code);
    logic [4:0] ofs;
    ofs = 5'(code[AMC_SIGN_BIT-1:0]);
    if (!code[AMC_SIGN_BIT]) begin
      out_bit_of = inb + ofs;
    end else if (inb > ofs) begin
      out_bit_of = inb - ofs;
    end else begin
      out_bit_of = AMC_BIT_MIN;
    end
  endfunction : out_bit_of

  // back-end reset period in ms, saturating at ten
  function automatic logic [AMC_FLD_W-1:0] be_ms_of(input logic [3:0] code);
    if (code > AMC_BE_MAX_MS) begin
      be_ms_of = AMC_BE_MAX_MS;
    end else begin
      be_ms_of = code;
    end
  endfunction : be_ms_of

  // read decode; shared by first and following read bytes
  function automatic logic [7:0] rd_mux(input logic [7:0] sub, input logic [7:0] r0,
                                        input logic [7:0] r1);
    if (sub == AMC_SUB_DTH) begin
      rd_mux = r0;
    end else if (sub == AMC_SUB_OTB) begin
      rd_mux = r1;
    end else begin
      rd_mux = AMC_RD_NONE;
    end
  endfunction : rd_mux

  // limit with only bit n set: magnitude below it counts as quiet
  function automatic logic [AMC_MAG_W-1:0] lim_of(input logic [4:0] b);
    lim_of = AMC_MAG_W'(1) << (b - AMC_BIT_MIN);
  endfunction : lim_of

  // three flops per pin; two of them before anything looks at them
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
    end
  end

  // bus events from the synchronised levels only
  always_comb begin
    scl_rise = scl_s2_reg && !scl_s3_reg;
    scl_fall = !scl_s2_reg && scl_s3_reg;
    start_det = scl_s2_reg && scl_s3_reg && sda_s3_reg && !sda_s2_reg;
    stop_det = scl_s2_reg && scl_s3_reg && !sda_s3_reg && sda_s2_reg;
    wr_stb = scl_fall && byte_done_reg && (state_reg == AMC_ST_WRITE);
    rd_byte = rd_mux(sub_reg, dth_reg, otb_reg);
  end

  // control port slave: address, subaddress, then auto-incrementing data
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= AMC_ST_IDLE;
      nxt_reg <= AMC_ST_IDLE;
      shift_reg <= 8'h00;
      sub_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte_done_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      // a repeated start keeps the subaddress for a following read
      state_reg <= AMC_ST_DEVADR;
      bit_cnt_reg <= 3'h0;
      byte_done_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= AMC_ST_IDLE;
      byte_done_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        AMC_ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        AMC_ST_DEVADR, AMC_ST_SUBADR, AMC_ST_WRITE: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s2_reg};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            byte_done_reg <= (bit_cnt_reg == AMC_BIT_LAST);
          end else if (scl_fall && byte_done_reg) begin
            byte_done_reg <= 1'b0;
            if (state_reg == AMC_ST_DEVADR && shift_reg[7:1] != AMC_DEV_ADDR) begin
              state_reg <= AMC_ST_IDLE; // not ours: stay off the bus
            end else begin
              state_reg <= AMC_ST_ACK;
              sda_oe_reg <= 1'b1;
            end
            if (state_reg == AMC_ST_DEVADR) begin
              nxt_reg <= shift_reg[0] ? AMC_ST_READ : AMC_ST_SUBADR;
            end else begin
              nxt_reg <= AMC_ST_WRITE;
            end
            if (state_reg == AMC_ST_SUBADR) begin
              sub_reg <= shift_reg;
            end else if (state_reg == AMC_ST_WRITE) begin
              sub_reg <= sub_reg + 8'h01;
            end
          end
        end
        AMC_ST_ACK: begin
          if (scl_fall) begin
            state_reg <= nxt_reg;
            bit_cnt_reg <= 3'h0;
            if (nxt_reg == AMC_ST_READ) begin
              shift_reg <= rd_byte;
              sda_oe_reg <= !rd_byte[7];
              sub_reg <= sub_reg + 8'h01;
            end else begin
              sda_oe_reg <= 1'b0;
            end
          end
        end
        AMC_ST_READ: begin
          if (scl_fall) begin
            if (bit_cnt_reg == AMC_BIT_LAST) begin
              state_reg <= AMC_ST_RACK;
              sda_oe_reg <= 1'b0;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_reg <= !shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
          end
        end
        AMC_ST_RACK: begin
          // a nack ends the read; an ack asks for the next byte
          if (scl_rise && sda_s2_reg) begin
            state_reg <= AMC_ST_IDLE;
          end else if (scl_fall) begin
            state_reg <= AMC_ST_READ;
            bit_cnt_reg <= 3'h0;
            shift_reg <= rd_byte;
            sda_oe_reg <= !rd_byte[7];
            sub_reg <= sub_reg + 8'h01;
          end
        end
        default: begin
          state_reg <= AMC_ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // register writes by subaddress; others are dropped
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dth_reg <= AMC_DTH_RST;
      otb_reg <= AMC_OTB_RST;
    end else if (wr_stb && sub_reg == AMC_SUB_DTH) begin
      dth_reg <= shift_reg;
    end else if (wr_stb && sub_reg == AMC_SUB_OTB) begin
      otb_reg <= shift_reg;
    end
  end

  // field decode, one stage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dly_ms_reg <= dly_ms_of(AMC_DTH_RST[AMC_LO_LSB +: AMC_FLD_W]);
      in_bit_reg <= AMC_BIT_MIN;
      out_bit_reg <= AMC_BIT_MIN;
      be_ms_reg <= '0;
    end else begin
      dly_ms_reg <= dly_ms_of(dth_reg[AMC_LO_LSB +: AMC_FLD_W]);
      in_bit_reg <= in_bit_of(dth_reg[AMC_HI_LSB +: AMC_FLD_W]);
      out_bit_reg <= out_bit_of(in_bit_of(dth_reg[AMC_HI_LSB +: AMC_FLD_W]),
                                otb_reg[AMC_HI_LSB +: AMC_FLD_W]);
      be_ms_reg <= be_ms_of(otb_reg[AMC_LO_LSB +: AMC_FLD_W]);
    end
  end

  // delay in cycles; split from decode to keep the multiply off the long path
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dly_cyc_reg <= AMC_CYC_W'(CYC_PER_MS);
    end else begin
      dly_cyc_reg <= AMC_CYC_W'(int'(dly_ms_reg) * CYC_PER_MS);
    end
  end

  // detector inputs
  always_comb begin
    det_smp[0] = in_sample;
    det_smp[1] = out_sample;
    det_lim[0] = lim_of(in_bit_reg);
    det_lim[1] = lim_of(out_bit_reg);
  end

  // both detectors share the one delay setting
  for (genvar g = 0; g < 2; g++) begin : g_det
    amc_mute_det u_det (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .sample(det_smp[g]),
      .limit(det_lim[g]),
      .delay_cyc(dly_cyc_reg),
      .mute_reg(det_mute[g])
    );
  end

  // outputs; the data pin only ever pulls low
  always_comb begin
    sda_out = 1'b0;
    sda_oe = sda_oe_reg;
    in_mute = det_mute[0];
    out_mute = det_mute[1];
    be_period_ms = be_ms_reg;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  delay_short_a: assert property (
    dth_reg[3:0] <= 4'h4 |=> dly_ms_reg == 7'($past(dth_reg[3:0])) + 7'h01)
    else $error("short delay code decoded wrong");

  delay_long_a: assert property (
    dth_reg[3:0] > 4'h4 |=> dly_ms_reg == 7'(($past(dth_reg[3:0]) - 4'h4) * 7'h0A))
    else $error("long delay code decoded wrong");

  delay_shared_a: assert property (
    ##1 dly_cyc_reg == AMC_CYC_W'(int'($past(dly_ms_reg)) * CYC_PER_MS))
    else $error("shared delay cycles wrong");

  in_thresh_a: assert property (
    ##1 in_bit_reg == (($past(dth_reg[7:4]) < 4'h2) ? 5'h01 : 5'($past(dth_reg[7:4]))))
    else $error("input threshold bit wrong");

  out_add_a: assert property (
    !otb_reg[7] |=> out_bit_reg == in_bit_reg + 5'($past(otb_reg[6:4])))
    else $error("output threshold add wrong");

  out_sub_a: assert property (
    otb_reg[7] && otb_reg[6:4] == 3'h0 |=> out_bit_reg == in_bit_reg)
    else $error("output threshold zero offset wrong");

  be_period_a: assert property (
    otb_reg[3:0] <= 4'hA |=> be_period_ms == $past(otb_reg[3:0]))
    else $error("reset period wrong");

  be_sat_a: assert property (
    otb_reg[3:0] > 4'hA |=> be_period_ms == 4'hA)
    else $error("reset period not saturated");

  reg_write_a: assert property (
    wr_stb && sub_reg == 8'h14 |=> dth_reg == $past(shift_reg) ##2 dly_ms_reg ==
      dly_ms_of($past(shift_reg[3:0], 3)))
    else $error("write not applied");

endmodule : amc_top

// ===== amc_host.sv
// Purpose: control bus host model that reads and writes the register bank
// Assumes: open drain data with a pull-up, scl phases of 8 core clocks
// Notes: host never stretches or arbitrates; released data reads high
`timescale 1ns/1ps
module amc_host (
  // clock
  input wire logic core_clk,
  // device data drive
  input wire logic sda_oe,
  input wire logic sda_out,
  // bus lines seen by the device
  output logic scl,
  output logic sda
);
  import amc_pkg::*;
  logic sda_rel;
  // wired and of host release and device pull-down, pull-up otherwise
  assign sda = sda_rel & !(sda_oe & !sda_out);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // start or repeated start: data falls while the clock is high
  task automatic bus_start();
    sda_rel <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_rel <= 1'b0;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask : bus_start
  task automatic bus_stop();
    sda_rel <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_rel <= 1'b1;
    tick(8);
  endtask : bus_stop
  // one clock pulse; data sampled mid high, well clear of device changes
  task automatic pulse(output logic seen);
    tick(4);
    scl <= 1'b1;
    tick(4);
    seen = sda;
    tick(4);
    scl <= 1'b0;
    tick(4);
  endtask : pulse
  // byte out msb first, then the device ack bit
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      sda_rel <= b[i];
      pulse(seen);
    end
    sda_rel <= 1'b1;
    pulse(seen);
    ack = !seen;
  endtask : wr_byte
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic seen;
    sda_rel <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pulse(seen);
      b[i] = seen;
    end
    // data stays as left by the ack bit; the stop or start that follows sets it
    sda_rel <= last;
    pulse(seen);
  endtask : rd_byte
  // register write by subaddress
  task automatic reg_wr(input logic [6:0] adr, input logic [7:0] sub, input logic [7:0] d,
                        output logic ok);
    logic a0;
    logic a1;
    logic a2;
    bus_start();
    wr_byte({adr, 1'b0}, a0);
    wr_byte(sub, a1);
    wr_byte(d, a2);
    bus_stop();
    ok = a0 & a1 & a2;
  endtask : reg_wr
  // register read: subaddress write, repeated start, one byte nacked
  task automatic reg_rd(input logic [7:0] sub, output logic [7:0] d, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    bus_start();
    wr_byte({AMC_DEV_ADDR, 1'b0}, a0);
    wr_byte(sub, a1);
    bus_start();
    wr_byte({AMC_DEV_ADDR, 1'b1}, a2);
    rd_byte(1'b1, d);
    bus_stop();
    ok = a0 & a1 & a2;
  endtask : reg_rd
endmodule : amc_host

// ===== test_automute_control_regs.sv
// Purpose: self-checking bench for the automute settings register bank
// Assumes: ms shortened to 4 core clocks so long delays stay quick
// Notes: all register traffic goes through the host model on the control bus
`timescale 1ns/1ps
module test_automute_control_regs;
  import amc_pkg::*;
  localparam int CPM = 4;
  localparam logic signed [AMC_SMP_W-1:0] LOUD = 24'h7FFFFF;
  logic core_clk;
  logic sys_rst;
  logic scl;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic signed [AMC_SMP_W-1:0] in_sample;
  logic signed [AMC_SMP_W-1:0] out_sample;
  logic in_mute;
  logic out_mute;
  logic [AMC_FLD_W-1:0] be_period_ms;
  int n_mismatch = 0;
  int checked = 0;
  amc_top #(.CYC_PER_MS(CPM)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .in_sample(in_sample),
    .out_sample(out_sample), .in_mute(in_mute), .out_mute(out_mute),
    .be_period_ms(be_period_ms));
  amc_host i_host (.core_clk(core_clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl),
    .sda(sda));
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    logic ok;
    i_host.reg_wr(AMC_DEV_ADDR, sub, d, ok);
    chk("write ack", 32'h1, {31'h0, ok});
  endtask : wr
  task automatic rd(input logic [7:0] sub, input logic [7:0] exp);
    logic ok;
    logic [7:0] d;
    i_host.reg_rd(sub, d, ok);
    chk("read ack", 32'h1, {31'h0, ok});
    chk("read data", {24'h0, exp}, {24'h0, d});
  endtask : rd
  // quiet or loud sample on one side, then loud again must release within three clocks
  task automatic probe(input logic side, input logic signed [AMC_SMP_W-1:0] v, input logic exp);
    in_sample <= LOUD;
    out_sample <= LOUD;
    repeat (4) @(posedge core_clk);
    if (side) out_sample <= v;
    else in_sample <= v;
    repeat (12) @(posedge core_clk);
    chk("mute after quiet", {31'h0, exp}, {31'h0, side ? out_mute : in_mute});
    in_sample <= LOUD;
    out_sample <= LOUD;
    repeat (3) @(posedge core_clk);
    chk("release", 32'h0, {31'h0, side ? out_mute : in_mute});
  endtask : probe
  // reset values, unmapped place, foreign device address
  task automatic sc_reset();
    logic ok;
    chk("period at reset", 32'h0, {28'h0, be_period_ms});
    rd(AMC_SUB_DTH, AMC_DTH_RST);
    rd(AMC_SUB_OTB, AMC_OTB_RST);
    wr(8'h20, 8'h5A);
    rd(8'h20, AMC_RD_NONE);
    i_host.reg_wr(AMC_DEV_ADDR ^ 7'h01, AMC_SUB_DTH, 8'h77, ok);
    chk("foreign ack", 32'h0, {31'h0, ok});
    rd(AMC_SUB_DTH, AMC_DTH_RST);
  endtask : sc_reset
  // every reset period code, with read back
  task automatic sc_period();
    for (int c = 0; c < 16; c++) begin
      wr(AMC_SUB_OTB, 8'(c));
      rd(AMC_SUB_OTB, 8'(c));
      chk("period", (c > 10) ? 32'd10 : 32'(c), {28'h0, be_period_ms});
    end
  endtask : sc_period
  // every delay code, timed on the input side, output mute checked when input mute sets
  task automatic sc_delay();
    int d;
    int n;
    for (int c = 0; c < 16; c++) begin
      wr(AMC_SUB_DTH, 8'(c));
      d = ((c <= 4) ? c + 1 : (c - 4) * 10) * CPM;
      in_sample <= LOUD;
      out_sample <= LOUD;
      repeat (4) @(posedge core_clk);
      in_sample <= '0;
      out_sample <= '0;
      n = 0;
      while (in_mute !== 1'b1 && n < 1000) begin
        @(posedge core_clk);
        n++;
      end
      if (n >= 1000) begin
        n_mismatch++;
        $display("[FAIL] mute delay code %0d expected by %0d seen none", c, d + 3);
        stop_test();
      end
      chk("delay in window", 32'h1, {31'h0, (n >= d + 1 && n <= d + 3)});
      chk("shared delay", 32'h1, {31'h0, out_mute});
    end
  endtask : sc_delay
  // every input threshold code, quiet just under the limit, loud at it
  task automatic sc_inthr();
    int b;
    int lim;
    for (int c = 0; c < 16; c++) begin
      wr(AMC_SUB_DTH, 8'(c << 4));
      b = (c < 2) ? 1 : c;
      lim = 1 << (b - 1);
      probe(1'b0, 24'(lim - 1), 1'b1);
      probe(1'b0, 24'(lim), 1'b0);
      probe(1'b0, 24'(-lim), 1'b0);
    end
  endtask : sc_inthr
  // every output offset code around an input threshold of bit 4
  task automatic sc_outthr();
    int b;
    int lim;
    wr(AMC_SUB_DTH, 8'h40);
    for (int c = 0; c < 16; c++) begin
      wr(AMC_SUB_OTB, 8'(c << 4));
      b = (c >= 8) ? 4 - (c - 8) : 4 + c;
      if (b < 1) b = 1;
      lim = 1 << (b - 1);
      probe(1'b1, 24'(lim - 1), 1'b1);
      probe(1'b1, 24'(lim), 1'b0);
    end
  endtask : sc_outthr
  // free running core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // reset, then scenarios in order
  initial begin
    sys_rst = 1'b1;
    in_sample = '0;
    out_sample = '0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    sc_reset();
    sc_period();
    sc_delay();
    sc_inthr();
    sc_outthr();
    stop_test();
  end
endmodule : test_automute_control_regs
